// file: core/swt_pkg.sv
// constants, types and encodings for the status-word transfer execution block
// assumes a single core clock and a plain register port on the main module
package swt_pkg;

    localparam int          COND_HI      = 31;
    localparam int          COND_LO      = 28;
    localparam int          SEL_BIT      = 22;
    localparam int          RD_HI        = 15;
    localparam int          RD_LO        = 12;
    localparam int          IMM_BIT      = 25;
    localparam int          FLAG_LO      = 28;
    localparam int          MODE_W       = 5;
    localparam logic [4:0]  MODE_USR     = 5'h10;
    localparam logic [4:0]  MODE_FIQ     = 5'h11;
    localparam logic [4:0]  MODE_IRQ     = 5'h12;
    localparam logic [4:0]  MODE_SVC     = 5'h13;
    localparam logic [4:0]  MODE_ABT     = 5'h17;
    localparam logic [4:0]  MODE_UND     = 5'h1b;
    localparam logic [4:0]  MODE_SYS     = 5'h1f;
    localparam logic [31:0] STATUS_RST   = 32'h000000d3;
    localparam logic [31:0] SAVED_RST    = 32'h00000000;
    localparam logic [3:0]  PC_REG       = 4'hf;
    // read form: cond 00010 P 001111 Rd 000000000000
    localparam logic [31:0] READ_MASK    = 32'h0fbf0fff;
    localparam logic [31:0] READ_MATCH   = 32'h010f0000;
    // whole write: cond 00010 P 1010011111 00000000 Rm
    localparam logic [31:0] WRALL_MASK   = 32'h0fbffff0;
    localparam logic [31:0] WRALL_MATCH  = 32'h0129f000;
    // flags-only write: cond 00 I 10 P 1010001111 source
    localparam logic [31:0] WRFLG_MASK   = 32'h0dbff000;
    localparam logic [31:0] WRFLG_MATCH  = 32'h0128f000;
    // register offsets on the plain port
    localparam logic [3:0]  OFS_INSTR    = 4'h0;
    localparam logic [3:0]  OFS_SRC      = 4'h1;
    localparam logic [3:0]  OFS_STATUS   = 4'h2;
    localparam logic [3:0]  OFS_RESULT   = 4'h3;
    localparam logic [3:0]  OFS_SAVED    = 4'h4;
    localparam logic [3:0]  OFS_LAST     = 4'h5;

    typedef enum logic [1:0] {SWT_NONE, SWT_READ, SWT_WRALL, SWT_WRFLG} swt_kind_t;

    typedef struct packed {
        swt_kind_t  kind;
        logic       use_saved;
        logic [3:0] reg_num;
        logic [3:0] cond;
        logic       imm;
    } swt_dec_t;

endpackage : swt_pkg

// file: core/swt_decode.sv
// instruction decoder for the status-word transfers
// assumes a 32-bit instruction word from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module swt_decode
    import swt_pkg::*;
(
    // instruction in
    input  wire logic [31:0] instr,
    // decoded fields out
    output swt_dec_t         dec
);
    always_comb begin
        dec           = '0;
        dec.kind      = SWT_NONE;
        dec.cond      = instr[COND_HI:COND_LO];
        dec.use_saved = instr[SEL_BIT];
        dec.imm       = instr[IMM_BIT];
        // compare-class opcodes with flag bit clear carry these forms
        if ((instr & READ_MASK) == READ_MATCH) begin
            dec.kind    = SWT_READ;
            dec.reg_num = instr[RD_HI:RD_LO];
        end else if ((instr & WRALL_MASK) == WRALL_MATCH) begin
            dec.kind    = SWT_WRALL;
            dec.reg_num = instr[3:0];
        end else if ((instr & WRFLG_MASK) == WRFLG_MATCH) begin
            dec.kind    = SWT_WRFLG;
            dec.reg_num = instr[3:0];
        end
    end
endmodule : swt_decode
`default_nettype wire

// file: core/swt_exec.sv
// status-word transfer execution: current and banked saved words
// assumes a plain register port; a write to the instruction offset executes it
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module swt_exec
    import swt_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    // status view
    output logic [31:0]      status_word,
    output logic             exec_done
);
    swt_dec_t    dec;
    logic [31:0] instr_in;
    logic [31:0] src;
    logic [31:0] result;
    logic [31:0] last;
    logic [31:0] saved [5];
    logic [2:0]  bank_idx;
    logic        bank_ok;
    logic        cond_pass;
    logic        go;
    logic [31:0] operand;
    logic [31:0] target;
    logic [31:0] merged;
    logic [31:0] next_status;
    logic [31:0] next_result;
    logic [31:0] next_src;
    logic [31:0] next_last;
    logic [31:0] next_rdata;
    logic        next_done;
    logic [31:0] next_saved [5];
    logic        n_f, z_f, c_f, v_f;

    assign instr_in = wdata;

    swt_decode u_dec (
        .instr (instr_in),
        .dec   (dec)
    );

    assign n_f = status_word[31];
    assign z_f = status_word[30];
    assign c_f = status_word[29];
    assign v_f = status_word[28];

    // condition
    always_comb begin
        unique case (dec.cond)
            4'h0: cond_pass = z_f;
            4'h1: cond_pass = !z_f;
            4'h2: cond_pass = c_f;
            4'h3: cond_pass = !c_f;
            4'h4: cond_pass = n_f;
            4'h5: cond_pass = !n_f;
            4'h6: cond_pass = v_f;
            4'h7: cond_pass = !v_f;
            4'h8: cond_pass = c_f && !z_f;
            4'h9: cond_pass = !c_f || z_f;
            4'ha: cond_pass = (n_f == v_f);
            4'hb: cond_pass = (n_f != v_f);
            4'hc: cond_pass = !z_f && (n_f == v_f);
            4'hd: cond_pass = z_f || (n_f != v_f);
            4'he: cond_pass = 1'b1;
            4'hf: cond_pass = 1'b0;
        endcase
    end

    // banked saved word picked from the mode now in force
    always_comb begin
        bank_ok  = 1'b1;
        bank_idx = 3'h0;
        unique case (status_word[MODE_W-1:0])
            MODE_FIQ: bank_idx = 3'h0;
            MODE_IRQ: bank_idx = 3'h1;
            MODE_SVC: bank_idx = 3'h2;
            MODE_ABT: bank_idx = 3'h3;
            MODE_UND: bank_idx = 3'h4;
            // no saved word here, access is dropped
            default:  bank_ok  = 1'b0;
        endcase
    end

    // program counter register as operand is software's fault, not trapped
    // a saved-word access with no bank is refused outright, no done pulse
    assign go      = wr && (addr == OFS_INSTR) && (dec.kind != SWT_NONE) && cond_pass
                     && (!dec.use_saved || bank_ok);
    assign operand = dec.imm ? src : src;
    assign target  = dec.use_saved ? saved[bank_idx] : status_word;

    // flags-only merge keeps control bits
    assign merged = {operand[31:FLAG_LO], target[FLAG_LO-1:0]};

    always_comb begin
        next_status = status_word;
        next_result = result;
        next_src    = src;
        next_last   = last;
        next_done   = 1'b0;
        next_rdata  = 32'h00000000;
        for (int i = 0; i < 5; i++) begin
            next_saved[i] = saved[i];
        end
        if (wr && addr == OFS_SRC) begin
            next_src = wdata;
        end
        if (wr && addr == OFS_STATUS) begin
            next_status = wdata;
        end
        if (wr && addr == OFS_SAVED && bank_ok) begin
            next_saved[bank_idx] = wdata;
        end
        if (wr && addr == OFS_INSTR) begin
            next_last = wdata;
        end
        if (go) begin
            next_done = 1'b1;
            unique case (dec.kind)
                SWT_READ: begin
                    if (!dec.use_saved) begin
                        next_result = status_word;
                    end else if (bank_ok) begin
                        next_result = saved[bank_idx];
                    end
                end
                SWT_WRALL, SWT_WRFLG: begin
                    if (dec.use_saved) begin
                        if (bank_ok) begin
                            next_saved[bank_idx] = (dec.kind == SWT_WRALL) ? operand : merged;
                        end
                    end else if (dec.kind == SWT_WRFLG ||
                                 status_word[MODE_W-1:0] == MODE_USR) begin
                        // user mode keeps control bits
                        next_status = {operand[31:FLAG_LO], status_word[FLAG_LO-1:0]};
                    end else begin
                        next_status = operand;
                    end
                end
                default: begin
                    next_done = 1'b0;
                end
            endcase
        end
        if (rd) begin
            unique case (addr)
                OFS_SRC:    next_rdata = src;
                OFS_STATUS: next_rdata = status_word;
                OFS_RESULT: next_rdata = result;
                OFS_SAVED:  next_rdata = bank_ok ? saved[bank_idx] : 32'h00000000;
                OFS_LAST:   next_rdata = last;
                default:    next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            status_word <= STATUS_RST;
            result      <= 32'h00000000;
            src         <= 32'h00000000;
            last        <= 32'h00000000;
            rdata       <= 32'h00000000;
            exec_done   <= 1'b0;
            for (int i = 0; i < 5; i++) begin
                saved[i] <= SAVED_RST;
            end
        end else begin
            status_word <= next_status;
            result      <= next_result;
            src         <= next_src;
            last        <= next_last;
            rdata       <= next_rdata;
            exec_done   <= next_done;
            for (int i = 0; i < 5; i++) begin
                saved[i] <= next_saved[i];
            end
        end
    end

    sequence s_instr_go;
        go;
    endsequence

    a_cond_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        (wr && addr == OFS_INSTR && !cond_pass) |=> !exec_done)
        else $error("failed condition still executed");
    a_done_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_instr_go |=> exec_done)
        else $error("passed transfer not executed");
    a_read_current: assert property (@(posedge core_clk) disable iff (sys_rst)
        (go && dec.kind == SWT_READ && !dec.use_saved) |=> (result == $past(status_word)))
        else $error("read of current word wrong");
    a_user_guard: assert property (@(posedge core_clk) disable iff (sys_rst)
        (go && !dec.use_saved && status_word[4:0] == MODE_USR)
        |=> (status_word[27:0] == $past(status_word[27:0])))
        else $error("user mode changed control bits");
    a_flags_only: assert property (@(posedge core_clk) disable iff (sys_rst)
        (go && dec.kind == SWT_WRFLG && !dec.use_saved)
        |=> (status_word[31:28] == $past(src[31:28])) && (status_word[27:0] == $past(status_word[27:0])))
        else $error("flags-only write wrong");
    a_full_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        (go && dec.kind == SWT_WRALL && !dec.use_saved && status_word[4:0] != MODE_USR)
        |=> (status_word == $past(src)))
        else $error("privileged full write wrong");
    a_user_nosave: assert property (@(posedge core_clk) disable iff (sys_rst)
        (status_word[4:0] == MODE_USR) |-> !bank_ok)
        else $error("user mode reached a saved word");
    a_fiq_bank: assert property (@(posedge core_clk) disable iff (sys_rst)
        (status_word[4:0] == MODE_FIQ) |-> (bank_ok && bank_idx == 3'h0))
        else $error("fast-interrupt bank not selected");
    a_read_dest: assert property (@(posedge core_clk) disable iff (sys_rst)
        (dec.kind == SWT_READ) |-> (dec.reg_num == instr_in[15:12]))
        else $error("read destination field wrong");
endmodule : swt_exec
`default_nettype wire

// file: sim/status_word_transfer_exec_tb.sv
// self-checking bench for the status-word transfer execution block
// assumes swt_exec on a 10 MHz core clock, driven through its plain register port
`timescale 1ns/1ps
`default_nettype none
module status_word_transfer_exec_tb;
    import swt_pkg::*;

    logic        core_clk;
    logic        sys_rst;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [31:0] status_word;
    logic        exec_done;
    int          failures;
    int          total_checks;

    swt_exec dut_u (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .addr        (addr),
        .wdata       (wdata),
        .wr          (wr),
        .rd          (rd),
        .rdata       (rdata),
        .status_word (status_word),
        .exec_done   (exec_done)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    // one-cycle strobe; returns just after the edge that took it, outputs settled
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge core_clk);
        wr    <= 1'b0;
        #1;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1;
        chk_word(rdata, exp);
    endtask : rd_chk

    // operand first, then the instruction that consumes it
    task automatic xfer(input logic [31:0] src, input logic [31:0] ins, input logic done);
        wr_reg(OFS_SRC, src);
        wr_reg(OFS_INSTR, ins);
        chk_bit(exec_done, done);
    endtask : xfer

    initial begin
        sys_rst  = 1'b1;
        addr     = 4'h0;
        wdata    = 32'h00000000;
        wr       = 1'b0;
        rd       = 1'b0;
        failures = 0;
        total_checks = 0;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        // register numbers stay below 15 throughout
        chk_word(status_word, STATUS_RST);
        rd_chk(OFS_STATUS, 32'h000000d3);
        xfer(32'h0, 32'he10f1000, 1'b1);
        rd_chk(OFS_RESULT, 32'h000000d3);
        xfer(32'h0, 32'he11f1000, 1'b0);
        chk_word(status_word, 32'h000000d3);
        // privileged whole writes: fiq, then its saved word
        xfer(32'h000000d1, 32'he129f001, 1'b1);
        chk_word(status_word, 32'h000000d1);
        xfer(32'h300000d3, 32'he169f001, 1'b1);
        rd_chk(OFS_SAVED, 32'h300000d3);
        // irq has a saved word of its own
        xfer(32'h000000d2, 32'he129f001, 1'b1);
        rd_chk(OFS_SAVED, 32'h00000000);
        xfer(32'h600000d7, 32'he169f001, 1'b1);
        xfer(32'h0, 32'he14f1000, 1'b1);
        rd_chk(OFS_RESULT, 32'h600000d7);
        xfer(32'h000000d1, 32'he129f001, 1'b1);
        rd_chk(OFS_SAVED, 32'h300000d3);
        // flags only: register, immediate, saved target
        xfer(32'ha5555555, 32'he128f001, 1'b1);
        chk_word(status_word, 32'ha00000d1);
        xfer(32'h5fffffff, 32'he328f000, 1'b1);
        chk_word(status_word, 32'h500000d1);
        xfer(32'hc0000000, 32'he168f001, 1'b1);
        rd_chk(OFS_SAVED, 32'hc00000d3);
        // z is set now: ne must skip, eq must run
        xfer(32'h000000d2, 32'h1129f001, 1'b0);
        chk_word(status_word, 32'h500000d1);
        xfer(32'h80000000, 32'h0128f001, 1'b1);
        chk_word(status_word, 32'h800000d1);
        // user mode: control bits locked, no saved word
        xfer(32'h00000010, 32'he129f001, 1'b1);
        xfer(32'hf00000d3, 32'he129f001, 1'b1);
        chk_word(status_word, 32'hf0000010);
        xfer(32'h0, 32'he14f1000, 1'b0);
        rd_chk(OFS_RESULT, 32'h600000d7);
        xfer(32'h12345678, 32'he169f001, 1'b0);
        rd_chk(OFS_LAST, 32'he169f001);
        // a write to an unmapped offset must leave the word alone
        wr_reg(4'h9, 32'h000000d3);
        chk_word(status_word, 32'hf0000010);
        // second reset in mid-run clears the banked words too
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        chk_word(status_word, STATUS_RST);
        xfer(32'h000000d1, 32'he129f001, 1'b1);
        rd_chk(OFS_SAVED, SAVED_RST);
        close_out();
    end

    // the sequence needs about 107 cycles; far beyond that is a hang
    initial begin
        #500000;
        failures++;
        close_out();
    end
endmodule : status_word_transfer_exec_tb
`default_nettype wire
